// ### rtl/smr_cfg.svh
// constants of the satellite manchester receiver
// assumes a 5 ns system clock; included by package and modules
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH
`define SMR_CLK_NS 5
`define SMR_CYC_UP(ns) (((ns) + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_CYC_DN(ns) ((ns) / `SMR_CLK_NS)
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SMR_STARTUP_NS 28650
`define SMR_FAULT_NS 200000
`define SMR_R0_MIN_NS 15000
`define SMR_R0_MAX_NS 25000
`define SMR_R1_MIN_NS 7500
`define SMR_R1_MAX_NS 12500
`define SMR_R2_MIN_NS 30000
`define SMR_R2_MAX_NS 50000
`define SMR_R3_MIN_NS 3750
`define SMR_R3_MAX_NS 6250
// ---------------------------------------------------------------
// framing and fifo
// ---------------------------------------------------------------
`define SMR_DATA_W 12
`define SMR_SH_W 17
`define SMR_A_BITS 5'h11
`define SMR_B_BASE 5'h09
`define SMR_CRC_POLY 5'h05
`define SMR_CRC_SEED 5'h00
`define SMR_FIFO_DEPTH 2
`endif

// ### rtl/smr_pkg.sv
// types of the satellite manchester receiver
// assumes smr_cfg.svh on the include path
`include "smr_cfg.svh"
package smr_pkg;
  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_IDLE = 3'b001,
    S_HUNT = 3'b010,
    S_SYNC = 3'b011,
    S_DATA = 3'b100
  } smr_state_t;
  typedef enum logic [1:0] {
    C_OK = 2'b00,
    C_BITTIME = 2'b01,
    C_TOOMANY = 2'b10,
    C_COMM = 2'b11
  } smr_code_t;
  typedef struct packed {
    smr_code_t code;
    logic [`SMR_DATA_W-1:0] data;
  } smr_entry_t;
  typedef struct packed {
    smr_state_t st;
    logic [15:0] ctr;
    logic [15:0] quiet;
    logic [15:0] bref;
    logic early;
    logic [4:0] nbits;
    logic [`SMR_SH_W-1:0] sh;
    logic line;
    logic [15:0] ocnt;
    logic oc;
    logic sw;
    smr_entry_t rd;
  } smr_ch_t;
  typedef struct packed {
    smr_ch_t [1:0] ch;
    logic [15:0] boot;
    logic booted;
    logic message_waiting_out;
  } smr_top_t;
endpackage

// ### rtl/smr_fifo_if.sv
// link between a decoder channel and its result fifo
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface smr_fifo_if;
  import smr_pkg::*;
  logic push;
  smr_entry_t wdata;
  logic pop;
  logic flush;
  smr_entry_t head;
  logic [1:0] count;
  logic lost;
  modport fifo(input push, wdata, pop, flush,
    output head, count, lost);
  modport user(output push, wdata, pop, flush,
    input head, count, lost);
endinterface

// ### rtl/smr_fifo.sv
// result fifo of one channel, oldest entry dropped on overflow
// assumes pop and flush are one-cycle pulses from the top
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_fifo import smr_pkg::*; #(
  parameter int DEPTH = `SMR_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  smr_fifo_if.fifo f
);
  typedef struct packed {
    smr_entry_t [DEPTH-1:0] e;
    logic [1:0] cnt;
    logic lost;
  } smr_fifo_t;
  smr_fifo_t s;
  smr_fifo_t next_s;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (f.flush) begin
      next_s.cnt = 2'h0;
      next_s.lost = 1'b0;
    end else if (f.pop && s.cnt != 2'h0) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        next_s.e[k] = s.e[k+1];
      end
      next_s.cnt = s.cnt - 2'h1;
      next_s.lost = 1'b0;
    end
    if (f.push) begin
      if (next_s.cnt == 2'(DEPTH)) begin
        for (int k = 0; k < DEPTH - 1; k++) begin
          next_s.e[k] = next_s.e[k+1];
        end
        next_s.e[DEPTH-1] = f.wdata;
        next_s.lost = 1'b1;
      end else begin
        next_s.e[next_s.cnt] = f.wdata;
        next_s.cnt = next_s.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign f.head = s.e[0];
  assign f.count = s.cnt;
  assign f.lost = s.lost;
endmodule

// ### rtl/smr_top.sv
// two-channel satellite manchester receiver with result fifos
// assumes comparator streams and config bits synchronous to CLK_IN
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_top import smr_pkg::*; #(
  parameter logic [15:0] STARTUP_CYC =
    16'(`SMR_CYC_UP(`SMR_STARTUP_NS)),
  parameter logic [15:0] FAULT_CYC =
    16'(`SMR_CYC_DN(`SMR_FAULT_NS)),
  parameter logic [15:0] RMIN_CYC [4] = '{
    16'(`SMR_CYC_UP(`SMR_R0_MIN_NS)),
    16'(`SMR_CYC_UP(`SMR_R1_MIN_NS)),
    16'(`SMR_CYC_UP(`SMR_R2_MIN_NS)),
    16'(`SMR_CYC_UP(`SMR_R3_MIN_NS))},
  parameter logic [15:0] RMAX_CYC [4] = '{
    16'(`SMR_CYC_DN(`SMR_R0_MAX_NS)),
    16'(`SMR_CYC_DN(`SMR_R1_MAX_NS)),
    16'(`SMR_CYC_DN(`SMR_R2_MAX_NS)),
    16'(`SMR_CYC_DN(`SMR_R3_MAX_NS))}
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] SAT_LINE_IN,
  input wire logic [1:0] SAT_ENABLE_IN,
  input wire logic [1:0] DECODE_ENABLE_IN,
  input wire logic [1:0] PROTO_B_IN,
  input wire logic ODD_PARITY_IN,
  input wire logic MSG_ACTIVE_LOW_IN,
  input wire logic MSG_QUIET_IN,
  input wire logic SAT_SELECT_IN,
  input wire logic [3:0] SPEED_RANGE_IN,
  input wire logic [3:0] B_LENGTH_IN,
  input wire logic [1:0] CUR_LIMIT_IN,
  input wire logic [1:0] REENABLE_IN,
  input wire logic [1:0] READ_IN,
  input wire logic [1:0] FLUSH_IN,
  output logic SATELLITE_OUTPUT_ONE_OUT,
  output logic SATELLITE_OUTPUT_TWO_OUT,
  output logic [1:0] OVERCURRENT_OUT,
  output logic [27:0] READ_DATA_OUT,
  output logic [1:0] DATA_LOST_OUT,
  output logic MESSAGE_WAITING_OUT
);
  smr_top_t s;
  smr_top_t next_s;
  logic [1:0] edg;
  logic [1:0] rise;
  logic [1:0] bt_ev;
  logic [1:0] tmb_ev;
  logic [1:0] cen_ev;
  logic [1:0] done_ev;
  logic [1:0] comm_bad;
  logic [1:0] push;
  smr_entry_t [1:0] wd;
  logic [1:0][15:0] rmin;
  logic [1:0][15:0] rmax;
  logic [1:0][15:0] lo;
  logic [1:0][15:0] hi;
  logic [1:0][15:0] idle;
  logic [1:0][4:0] expn;
  logic [1:0] any_msg;
  // fifo views as plain arrays; loop index cannot pick an interface
  logic [1:0][1:0] f_count;
  smr_entry_t [1:0] f_head;

  smr_fifo_if fi[2] ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // crc over data, x5+x2+1
  function automatic logic [4:0] crc5(input logic [11:0] d);
    logic [4:0] c;
    logic fb;
    c = `SMR_CRC_SEED;
    for (int k = 11; k >= 0; k--) begin
      fb = c[4] ^ d[k];
      c = {c[3:0], 1'b0};
      if (fb) begin
        c = c ^ `SMR_CRC_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    smr_ch_t c;
    logic [10:0] mask;
    logic [1:0] blen;
    c = '0;
    mask = '0;
    blen = '0;
    next_s = s;
    edg = '0;
    rise = '0;
    bt_ev = '0;
    tmb_ev = '0;
    cen_ev = '0;
    done_ev = '0;
    comm_bad = '0;
    push = '0;
    wd = '0;
    rmin = '0;
    rmax = '0;
    lo = '0;
    hi = '0;
    idle = '0;
    expn = '0;
    any_msg = '0;
    if (!s.booted) begin
      next_s.boot = inc(s.boot);
      next_s.booted = (inc(s.boot) >= STARTUP_CYC);
    end
    for (int i = 0; i < 2; i++) begin
      c = s.ch[i];
      blen = B_LENGTH_IN[2*i+:2];
      rmin[i] = RMIN_CYC[SPEED_RANGE_IN[2*i+:2]];
      rmax[i] = RMAX_CYC[SPEED_RANGE_IN[2*i+:2]];
      // window is 75 to 125 percent
      lo[i] = s.ch[i].bref - {2'b00, s.ch[i].bref[15:2]};
      hi[i] = s.ch[i].bref + {2'b00, s.ch[i].bref[15:2]};
      // idle is 150 percent of range minimum
      idle[i] = rmin[i] + {1'b0, rmin[i][15:1]};
      expn[i] = PROTO_B_IN[i] ? `SMR_B_BASE + 5'(blen)
                              : `SMR_A_BITS;
      edg[i] = SAT_LINE_IN[i] != s.ch[i].line;
      rise[i] = edg[i] & SAT_LINE_IN[i];
      c.line = SAT_LINE_IN[i];
      c.ctr = inc(s.ch[i].ctr);
      c.quiet = edg[i] ? 16'h0000 : inc(s.ch[i].quiet);
      if (!DECODE_ENABLE_IN[i] || !s.booted) begin
        c.st = S_OFF;
        c.bref = rmin[i];
      end else begin
        case (s.ch[i].st)
          S_OFF: begin
            c.st = S_IDLE;
            c.quiet = 16'h0000;
          end
          S_IDLE: begin
            if (c.quiet >= idle[i]) begin
              c.st = S_HUNT;
            end
          end
          S_HUNT: begin
            if (rise[i]) begin
              c.st = S_SYNC;
              c.ctr = 16'h0000;
            end
          end
          S_SYNC: begin
            if (rise[i]) begin
              if (c.ctr < rmin[i] || c.ctr > rmax[i]) begin
                bt_ev[i] = 1'b1;
              end else begin
                c.bref = c.ctr;
                c.st = S_DATA;
                // one, so ctr is cycles since centre
                c.ctr = 16'h0001;
                c.nbits = 5'h00;
                c.early = 1'b0;
              end
            end else if (c.ctr > rmax[i]) begin
              bt_ev[i] = 1'b1;
            end
          end
          S_DATA: begin
            if (edg[i] && s.ch[i].ctr < lo[i]) begin
              // one early edge is a boundary
              // a second one is an error
              if (s.ch[i].early) begin
                bt_ev[i] = 1'b1;
              end else begin
                c.early = 1'b1;
              end
            end else if (edg[i] && s.ch[i].ctr <= hi[i]) begin
              cen_ev[i] = 1'b1;
              c.sh = {s.ch[i].sh[15:0], ~rise[i]};
              c.nbits = s.ch[i].nbits + 5'h01;
              c.ctr = 16'h0001;
              c.early = 1'b0;
              if (s.ch[i].nbits >= expn[i]) begin
                tmb_ev[i] = 1'b1;
              end
            end else if (edg[i]) begin
              bt_ev[i] = 1'b1;
            end else if (s.ch[i].ctr > hi[i] &&
                s.ch[i].nbits < expn[i]) begin
              bt_ev[i] = 1'b1;
            end else if (c.quiet >= idle[i] &&
                s.ch[i].nbits == expn[i]) begin
              done_ev[i] = 1'b1;
            end
          end
          default: begin
            c.st = S_OFF;
          end
        endcase
      end
      if (bt_ev[i] || tmb_ev[i]) begin
        c.st = S_IDLE;
        c.bref = rmin[i];
      end
      mask = 11'(11'h7FF >> (2'h3 - blen));
      if (PROTO_B_IN[i]) begin
        comm_bad[i] = (^(s.ch[i].sh[11:0] & {mask, 1'b1}))
                      != ODD_PARITY_IN;
      end else begin
        comm_bad[i] = crc5(s.ch[i].sh[16:5]) != s.ch[i].sh[4:0];
      end
      if (bt_ev[i]) begin
        push[i] = 1'b1;
        wd[i].code = C_BITTIME;
      end else if (tmb_ev[i]) begin
        push[i] = 1'b1;
        wd[i].code = C_TOOMANY;
      end else if (done_ev[i]) begin
        push[i] = 1'b1;
        c.st = S_HUNT;
        wd[i].code = comm_bad[i] ? C_COMM : C_OK;
        wd[i].data = PROTO_B_IN[i] ? {1'b0, s.ch[i].sh[11:1] & mask}
                                   : s.ch[i].sh[16:5];
      end
      if (s.ch[i].oc) begin
        c.ocnt = 16'h0000;
        c.oc = !(REENABLE_IN[i] && !CUR_LIMIT_IN[i]);
      end else if (CUR_LIMIT_IN[i] && s.ch[i].sw) begin
        c.ocnt = inc(s.ch[i].ocnt);
        c.oc = c.ocnt >= FAULT_CYC;
      end else begin
        c.ocnt = 16'h0000;
      end
      c.sw = SAT_ENABLE_IN[i] && !c.oc;
      if (READ_IN[i]) begin
        c.rd = (f_count[i] != 2'h0) ? f_head[i] : '0;
      end
      any_msg[i] = f_count[i] != 2'h0;
      next_s.ch[i] = c;
    end
    next_s.message_waiting_out = ((|any_msg) && !(MSG_QUIET_IN && SAT_SELECT_IN))
                 ^ MSG_ACTIVE_LOW_IN;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // fifos, one per channel
  // ---------------------------------------------------------------
  // two fourteen-bit entries each
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign fi[g].push = push[g];
    assign fi[g].wdata = wd[g];
    assign fi[g].pop = READ_IN[g];
    assign fi[g].flush = FLUSH_IN[g];
    assign f_count[g] = fi[g].count;
    assign f_head[g] = fi[g].head;
    assign DATA_LOST_OUT[g] = fi[g].lost;
    assign OVERCURRENT_OUT[g] = s.ch[g].oc;
    assign READ_DATA_OUT[14*g+:14] = s.ch[g].rd;

    smr_fifo #(
      .DEPTH(`SMR_FIFO_DEPTH)
    ) u_fifo (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .f(fi[g])
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_bt_revert:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      bt_ev[g] |=> s.ch[g].st == S_IDLE &&
        s.ch[g].bref == $past(rmin[g]))
    else $error("timing error did not restore minimum");
    a_err_push:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (bt_ev[g] || tmb_ev[g]) |-> push[g] && wd[g].code != C_OK)
    else $error("error not pushed at once");
    a_center_win:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      cen_ev[g] |-> s.ch[g].ctr >= lo[g] && s.ch[g].ctr <= hi[g])
    else $error("bit centre outside window");
    a_early_ignore:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (s.ch[g].st == S_DATA && edg[g] && s.ch[g].ctr < lo[g] &&
        !s.ch[g].early && DECODE_ENABLE_IN[g])
      |=> s.ch[g].early && $stable(s.ch[g].nbits))
    else $error("early edge changed bit count");
    a_bit_value:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      cen_ev[g] |=> s.ch[g].sh[0] == !$past(rise[g]))
    else $error("bit value wrong for edge direction");
    a_crc_fault:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (done_ev[g] && !PROTO_B_IN[g] &&
        crc5(s.ch[g].sh[16:5]) != s.ch[g].sh[4:0])
      |-> wd[g].code == C_COMM)
    else $error("crc mismatch not reported");
    a_lost_set:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (push[g] && fi[g].count == 2'h2 && !READ_IN[g] &&
        !FLUSH_IN[g]) |=> fi[g].lost && fi[g].count == 2'h2)
    else $error("overflow did not set lost flag");
    a_fill_clean:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (push[g] && fi[g].count == 2'h1 && !fi[g].lost &&
        !READ_IN[g]) |=> !fi[g].lost ##1 1'b1)
    else $error("filling to capacity set lost flag");
    a_lost_clear:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ((READ_IN[g] || FLUSH_IN[g]) && !push[g]) |=> !fi[g].lost)
    else $error("read or flush left lost flag");
    a_oc_latch:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (s.ch[g].oc && !REENABLE_IN[g]) |=> s.ch[g].oc && !s.ch[g].sw)
    else $error("latched channel came back alone");
    a_boot_quiet:
    assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !s.booted |-> !push[g])
    else $error("decoded before startup wait");
  end

  a_msg_wait:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (!MSG_QUIET_IN && !MSG_ACTIVE_LOW_IN &&
      (fi[0].count != 2'h0 || fi[1].count != 2'h0))
    |=> MESSAGE_WAITING_OUT)
  else $error("message waiting not shown");
  a_msg_polarity:
  assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (MSG_ACTIVE_LOW_IN && fi[0].count == 2'h0 &&
      fi[1].count == 2'h0) |=> MESSAGE_WAITING_OUT)
  else $error("active low idle level wrong");

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SATELLITE_OUTPUT_ONE_OUT = s.ch[0].sw;
  assign SATELLITE_OUTPUT_TWO_OUT = s.ch[1].sw;
  assign MESSAGE_WAITING_OUT = s.message_waiting_out;
endmodule

// ### sim/smr_sat_model.sv
// satellite sensor model driving one comparator stream
// assumes send is called at a falling clock edge
`timescale 1ns/1ps
module smr_sat_model (
  input wire logic clk_in,
  output logic line_out
);
  initial line_out = 1'b0;
  // ------------------
  // message sender
  // ------------------
  // zero rises mid-bit
  task automatic send(input logic [19:0] b, input int n, input int t,
    input int gl);
    for (int i = n - 1; i >= 0; i--) begin
      line_out = b[i];
      repeat (t / 2) @(negedge clk_in);
      line_out = !b[i];
      if (i == gl) begin
        // two early edges, only when a scenario asks
        repeat (3) @(negedge clk_in);
        line_out = b[i];
        @(negedge clk_in);
        line_out = !b[i];
        repeat (t - t / 2 - 4) @(negedge clk_in);
      end else begin
        repeat (t - t / 2) @(negedge clk_in);
      end
    end
    // quiescent current reads low once the frame ends
    line_out = 1'b0;
  endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the satellite manchester receiver
// assumes smr_pkg compiled first; one sensor model per channel
`timescale 1ns/1ps
module tb_top;
  import smr_pkg::*;
  // ------------------
  // wiring
  // ------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] line, sat_en, dec_en, proto_b, cur_lim, reen, rd, fl;
  logic odd, act_low, quiet, sel, out1, out2, message_waiting_out;
  logic [3:0] spd, blen;
  logic [1:0] oc, lost;
  logic [1:0] rd_q = 2'h0;
  logic [27:0] rdata;
  logic [13:0] want;
  logic [13:0] expq[2][$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  smr_sat_model sat0 (.clk_in(clk), .line_out(line[0]));
  smr_sat_model sat1 (.clk_in(clk), .line_out(line[1]));
  // short counts keep the run brief; every range is 40 to 60 cycles
  smr_top #(
    .STARTUP_CYC(16'h0014),
    .FAULT_CYC(16'h0032),
    .RMIN_CYC('{4{16'h0028}}),
    .RMAX_CYC('{4{16'h003C}})
  ) DUT (
    .CLK_IN(clk), .RST_IN(rst), .SAT_LINE_IN(line),
    .SAT_ENABLE_IN(sat_en), .DECODE_ENABLE_IN(dec_en),
    .PROTO_B_IN(proto_b), .ODD_PARITY_IN(odd),
    .MSG_ACTIVE_LOW_IN(act_low), .MSG_QUIET_IN(quiet),
    .SAT_SELECT_IN(sel), .SPEED_RANGE_IN(spd), .B_LENGTH_IN(blen),
    .CUR_LIMIT_IN(cur_lim), .REENABLE_IN(reen), .READ_IN(rd),
    .FLUSH_IN(fl), .SATELLITE_OUTPUT_ONE_OUT(out1),
    .SATELLITE_OUTPUT_TWO_OUT(out2), .OVERCURRENT_OUT(oc),
    .READ_DATA_OUT(rdata), .DATA_LOST_OUT(lost),
    .MESSAGE_WAITING_OUT(message_waiting_out)
  );
  // ------------------
  // checking
  // ------------------
  task automatic check(input string name, input logic [13:0] seen,
    input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  // read data lands one edge after the pulse
  always @(negedge clk) begin
    for (int g = 0; g < 2; g++) begin
      if (rd_q[g]) begin
        want = expq[g].pop_front();
        check("entry", rdata[14*g+:14], want);
      end
    end
  end
  // ------------------
  // drivers
  // ------------------
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd_fifo(input int ch);
    rd[ch] = 1'b1;
    @(negedge clk);
    rd[ch] = 1'b0;
    cyc_n(2);
  endtask
  // idle is 60 cycles after the last edge, so 70 covers it
  task automatic send(input int ch, input logic [19:0] b, input int n,
    input int t, input int gl);
    if (ch == 0) sat0.send(b, n, t, gl);
    else sat1.send(b, n, t, gl);
    cyc_n(70);
  endtask
  function automatic logic [4:0] crc5(input logic [11:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 11; i >= 0; i--) begin
      c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h05 : 5'h00);
    end
    return c;
  endfunction
  task automatic send_a(input int ch, input int t, input logic [4:0] bad);
    logic [11:0] d;
    d = 12'($urandom);
    expq[ch].push_back({(bad != 5'h00) ? C_COMM : C_OK, d});
    send(ch, 20'({d, crc5(d) ^ bad}), 19, t, -1);
  endtask
  task automatic send_b(input int ch, input int len, input logic bad);
    logic [10:0] d;
    logic p;
    d = 11'($urandom) & ~(11'h7FF << (8 + len));
    p = ^d ^ odd ^ bad;
    expq[ch].push_back({bad ? C_COMM : C_OK, 1'b0, d});
    send(ch, 20'({d, p}), 11 + len, 50, -1);
  endtask
  task automatic err_exp(input smr_code_t c);
    expq[0].push_back({c, 12'h000});
  endtask
  // ------------------
  // scenarios
  // ------------------
  initial begin
    sat_en = 2'h3;
    dec_en = 2'h3;
    proto_b = 2'h0;
    {odd, act_low, quiet, sel} = 4'h0;
    spd = 4'h0;
    blen = 4'h0;
    {cur_lim, reen, rd, fl} = 8'h00;
    void'($urandom(43000));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    cyc_n(100);
    proto_b = 2'h2;
    spd = 4'($urandom);
    check("switch", 14'({oc, out1, out2}), 14'h0003);
    for (int t = 40; t <= 60; t += 10) begin
      send_a(0, t, 5'h00);
      check("msg", 14'(message_waiting_out), 14'h0001);
      rd_fifo(0);
      check("msg idle", 14'(message_waiting_out), 14'h0000);
    end
    send_a(0, 50, 5'h04);
    rd_fifo(0);
    for (int k = 0; k < 8; k++) begin
      blen[3:2] = 2'(k);
      odd = k[2];
      send_b(1, k % 4, 1'b0);
      rd_fifo(1);
    end
    send_b(1, 3, 1'b1);
    rd_fifo(1);
    // sync too slow for the range
    err_exp(C_BITTIME);
    // equal bits keep edges closer than idle, so one error only
    send(0, 20'h00000, 19, 70, -1);
    rd_fifo(0);
    // early pair beats the surplus bit
    err_exp(C_BITTIME);
    send(0, 20'h1A5A5, 20, 50, 12);
    rd_fifo(0);
    check("one code", 14'(message_waiting_out), 14'h0000);
    err_exp(C_BITTIME);
    send(0, 20'h0000F, 9, 40, -1);
    rd_fifo(0);
    err_exp(C_TOOMANY);
    sat0.send(20'h0ABCD, 20, 50, -1);
    check("early push", 14'(message_waiting_out), 14'h0001);
    cyc_n(70);
    rd_fifo(0);
    send_a(0, 40, 5'h00);
    rd_fifo(0);
    send_a(0, 50, 5'h00);
    send_a(0, 50, 5'h00);
    check("lost full", 14'(lost), 14'h0000);
    send_a(0, 50, 5'h00);
    check("lost", 14'(lost), 14'h0001);
    void'(expq[0].pop_front());
    rd_fifo(0);
    check("lost read", 14'(lost), 14'h0000);
    send_a(0, 50, 5'h00);
    send_a(0, 50, 5'h00);
    check("lost again", 14'(lost), 14'h0001);
    act_low = 1'b1;
    cyc_n(3);
    check("msg low", 14'(message_waiting_out), 14'h0000);
    {quiet, sel} = 2'h3;
    cyc_n(3);
    check("msg quiet", 14'(message_waiting_out), 14'h0001);
    quiet = 1'b0;
    cyc_n(3);
    check("msg select", 14'(message_waiting_out), 14'h0000);
    sel = 1'b0;
    fl[0] = 1'b1;
    @(negedge clk);
    fl[0] = 1'b0;
    cyc_n(3);
    expq[0].delete();
    // active low: empty fifos leave the output high
    check("flush", 14'({lost, message_waiting_out}), 14'h0001);
    act_low = 1'b0;
    cur_lim[1] = 1'b1;
    cyc_n(40);
    check("oc early", 14'({oc, out1, out2}), 14'h0003);
    for (int r = 0; r < 2; r++) begin
      cyc_n(20);
      // limit still on, or no re-enable: channel stays off
      cur_lim[1] = 1'(1 - r);
      reen[1] = 1'(1 - r);
      @(negedge clk);
      reen[1] = 1'b0;
      cyc_n(3);
      check("oc latch", 14'({oc, out1, out2}), 14'h000A);
      cur_lim[1] = 1'b0;
    end
    reen[1] = 1'b1;
    @(negedge clk);
    reen[1] = 1'b0;
    cyc_n(3);
    check("oc clear", 14'({oc, out1, out2}), 14'h0003);
    finish_test();
  end
endmodule
